// *** common/gtc_map.vh ***
/*
  Register map, field positions, reset values and constants of the global
  transceiver control register bank.
  Assumes: included by the bank's design file; word index equals the
  printed register offset, byte address is four times the index.
*/
`ifndef GTC_MAP_VH
`define GTC_MAP_VH

// ----------------------------------------------------------------------
// register indices (word addresses on the register bus)
// ----------------------------------------------------------------------
`define GTC_IDX_CTRL1       8'hF0
`define GTC_IDX_FRM_CTRL1   8'hF1
`define GTC_IDX_CTRL3       8'hF2
`define GTC_IDX_CLK_CTRL1   8'hF3
`define GTC_IDX_CLK_CTRL3   8'hF4
`define GTC_IDX_RSVD_F5     8'hF5
`define GTC_IDX_SW_RESET    8'hF6
`define GTC_IDX_RSVD_F7     8'hF7
`define GTC_IDX_DEV_ID      8'hF8
`define GTC_IDX_FRM_ISTAT   8'hF9
`define GTC_IDX_BERT_ISTAT  8'hFA
`define GTC_IDX_LIU_ISTAT   8'hFB
`define GTC_IDX_FRM_IMASK   8'hFC
`define GTC_IDX_BERT_IMASK  8'hFD
`define GTC_IDX_LIU_IMASK   8'hFE

// ----------------------------------------------------------------------
// control register one fields
// ----------------------------------------------------------------------
`define GTC_SEL_HI          7
`define GTC_SEL_LO          5
`define GTC_BIT_COMPAT      3
`define GTC_BIT_GANGED      2
`define GTC_BIT_LATCH       1
`define GTC_BIT_INHIBIT     0
`define GTC_CTRL1_WMASK     8'hEF
`define GTC_SEL_MAX         3'h5

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define GTC_RST_REG         8'h00
`define GTC_RST_WORD        32'h0000_0000
`define GTC_ID_VALUE        8'h5A
`define GTC_PORTS           4

`endif

// *** core/gtc_regbank.v ***
/*
  Global configuration and status register bank of a four-port framer and
  line-interface transceiver, reached over an Avalon-MM slave port with
  waitrequest. Holds control, clock control, software reset, device
  identification, and the framer, bit-error-tester and line-interface
  interrupt status and mask registers, plus the status pin routing, the
  pin-compatibility pin mux, bus multiplexer select and counter latch.
  Assumes: per-port event and status inputs come from logic on sys_clk_i;
  the bus master holds its request until it sees waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.vh"

// Contract
// - select field routes per-port status to groups
// - compat mode moves clock pins to status
// - compat cleared keeps normal pin assignment
// - ganged bit picks internal mux or wired-OR
// - ganged set disables internal interleave mux
// - latch bit rising edge latches enabled counters
// - each framer enables latch acceptance independently
// - framer interrupt status plus separate mask
// - tester and line status each with mask
// - identification register and software reset register
// - inhibit clear: pin low on unmasked interrupt
// - inhibit set: pin forced high
module gtc_regbank (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // avalon-mm slave
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  // per-port events from framers, testers and line interfaces
  input  wire [3:0]  framer_event_i,
  input  wire [3:0]  bert_event_i,
  input  wire [3:0]  liu_event_i,
  // per-port status sources
  input  wire [3:0]  rx_loss_of_frame_i,
  input  wire [3:0]  tx_clock_loss_i,
  input  wire [3:0]  alarm_output_i,
  input  wire [3:0]  rx_signaling_freeze_i,
  input  wire [3:0]  framer_loss_of_signal_i,
  // per-framer acceptance of the global counter latch
  input  wire [3:0]  framer_latch_en_i,
  // normal-mode source of the clock output pin
  input  wire        clock_output_src_i,
  // status output groups
  output reg  [3:0]  status_grp_a_o,
  output reg  [3:0]  status_grp_b_o,
  // shared pins (outputs and enables, ports four to two)
  output reg  [2:0]  rx_system_clock_o,
  output reg  [2:0]  rx_system_clock_oe_o,
  output reg  [2:0]  tx_system_clock_o,
  output reg  [2:0]  tx_system_clock_oe_o,
  output reg         clock_output_pin_o,
  output reg         serial_select_o,
  output reg         serial_select_oe_o,
  output reg         tx_sync_plain_o,
  // interleaved bus control
  output reg         int_mux_en_o,
  output reg         wired_or_en_o,
  // counter latch strobes
  output reg  [3:0]  counter_latch_o,
  // plain control registers
  output reg  [7:0]  framer_control_one_o,
  output reg  [7:0]  transceiver_control_three_o,
  output reg  [7:0]  clock_control_one_o,
  output reg  [7:0]  clock_control_three_o,
  output reg  [7:0]  software_reset_o,
  // interrupts
  output reg         irq_o,
  output reg         interrupt_pin_n_o
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [7:0]  ctrl1_q;
  reg  [7:0]  frm_ctrl1_q;
  reg  [7:0]  ctrl3_q;
  reg  [7:0]  clk_ctrl1_q;
  reg  [7:0]  clk_ctrl3_q;
  reg  [7:0]  sw_reset_q;
  reg  [3:0]  frm_istat_q;
  reg  [3:0]  bert_istat_q;
  reg  [3:0]  liu_istat_q;
  reg  [3:0]  frm_imask_q;
  reg  [3:0]  bert_imask_q;
  reg  [3:0]  liu_imask_q;
  reg         latch_prev_q;
  reg  [7:0]  rd_byte_d;

  wire        req_w;
  wire        take_w;
  wire        wr_w;
  wire [7:0]  wbyte_w;
  wire [2:0]  sel_w;
  wire        compat_w;
  wire [3:0]  frm_clr_w;
  wire [3:0]  bert_clr_w;
  wire [3:0]  liu_clr_w;
  wire        pending_w;

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  assign req_w   = avs_read_i | avs_write_i;
  // the request completes on the edge where waitrequest is seen low
  assign take_w  = req_w & ~avs_waitrequest_o;
  // only byte lane 0 carries data; other lanes are ignored
  assign wr_w    = take_w & avs_write_i & avs_byteenable_i[0];
  assign wbyte_w = avs_writedata_i[7:0];

  // waitrequest drops for one cycle, one cycle after the request rises
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= `GTC_RST_WORD;
    end else if (req_w & avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= {24'h00_0000, rd_byte_d};
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // unmapped and reserved locations read as zero
  always @* begin
    rd_byte_d = `GTC_RST_REG;
    case (avs_address_i)
      `GTC_IDX_CTRL1:      rd_byte_d = ctrl1_q;
      `GTC_IDX_FRM_CTRL1:  rd_byte_d = frm_ctrl1_q;
      `GTC_IDX_CTRL3:      rd_byte_d = ctrl3_q;
      `GTC_IDX_CLK_CTRL1:  rd_byte_d = clk_ctrl1_q;
      `GTC_IDX_CLK_CTRL3:  rd_byte_d = clk_ctrl3_q;
      `GTC_IDX_SW_RESET:   rd_byte_d = sw_reset_q;
      `GTC_IDX_DEV_ID:     rd_byte_d = `GTC_ID_VALUE;
      `GTC_IDX_FRM_ISTAT:  rd_byte_d = {4'h0, frm_istat_q};
      `GTC_IDX_BERT_ISTAT: rd_byte_d = {4'h0, bert_istat_q};
      `GTC_IDX_LIU_ISTAT:  rd_byte_d = {4'h0, liu_istat_q};
      `GTC_IDX_FRM_IMASK:  rd_byte_d = {4'h0, frm_imask_q};
      `GTC_IDX_BERT_IMASK: rd_byte_d = {4'h0, bert_imask_q};
      `GTC_IDX_LIU_IMASK:  rd_byte_d = {4'h0, liu_imask_q};
      default:             rd_byte_d = `GTC_RST_REG;
    endcase
  end

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  // everything resets to zero
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_q      <= `GTC_RST_REG;
      frm_ctrl1_q  <= `GTC_RST_REG;
      ctrl3_q      <= `GTC_RST_REG;
      clk_ctrl1_q  <= `GTC_RST_REG;
      clk_ctrl3_q  <= `GTC_RST_REG;
      sw_reset_q   <= `GTC_RST_REG;
      frm_imask_q  <= 4'h0;
      bert_imask_q <= 4'h0;
      liu_imask_q  <= 4'h0;
    end else if (wr_w) begin
      case (avs_address_i)
        // reserved bit 4 of control one stays zero
        `GTC_IDX_CTRL1:      ctrl1_q      <= wbyte_w & `GTC_CTRL1_WMASK;
        // framer side learns the bus layout here
        `GTC_IDX_FRM_CTRL1:  frm_ctrl1_q  <= wbyte_w;
        `GTC_IDX_CTRL3:      ctrl3_q      <= wbyte_w;
        `GTC_IDX_CLK_CTRL1:  clk_ctrl1_q  <= wbyte_w;
        `GTC_IDX_CLK_CTRL3:  clk_ctrl3_q  <= wbyte_w;
        `GTC_IDX_SW_RESET:   sw_reset_q   <= wbyte_w;
        `GTC_IDX_FRM_IMASK:  frm_imask_q  <= wbyte_w[3:0];
        `GTC_IDX_BERT_IMASK: bert_imask_q <= wbyte_w[3:0];
        `GTC_IDX_LIU_IMASK:  liu_imask_q  <= wbyte_w[3:0];
        // reserved and unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // sticky interrupt status, write one to clear
  // ----------------------------------------------------------------------
  assign frm_clr_w  = (wr_w && avs_address_i == `GTC_IDX_FRM_ISTAT)  ? wbyte_w[3:0] : 4'h0;
  assign bert_clr_w = (wr_w && avs_address_i == `GTC_IDX_BERT_ISTAT) ? wbyte_w[3:0] : 4'h0;
  assign liu_clr_w  = (wr_w && avs_address_i == `GTC_IDX_LIU_ISTAT)  ? wbyte_w[3:0] : 4'h0;

  // a new event in the clearing cycle survives: set beats clear
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frm_istat_q  <= 4'h0;
      bert_istat_q <= 4'h0;
      liu_istat_q  <= 4'h0;
    end else begin
      frm_istat_q  <= (frm_istat_q & ~frm_clr_w) | framer_event_i;
      bert_istat_q <= (bert_istat_q & ~bert_clr_w) | bert_event_i;
      liu_istat_q  <= (liu_istat_q & ~liu_clr_w) | liu_event_i;
    end
  end

  assign pending_w = |{frm_istat_q & frm_imask_q,
                       bert_istat_q & bert_imask_q,
                       liu_istat_q & liu_imask_q};

  // interrupt outputs lag the status by one cycle
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o             <= 1'b0;
      interrupt_pin_n_o <= 1'b1;
    end else begin
      irq_o             <= pending_w;
      // pin low only when pending and not inhibited
      interrupt_pin_n_o <= ~(pending_w & ~ctrl1_q[`GTC_BIT_INHIBIT]);
    end
  end

  // ----------------------------------------------------------------------
  // global counter latch
  // ----------------------------------------------------------------------
  // a held one produces no further strobe; software must toggle it
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_prev_q    <= 1'b0;
      counter_latch_o <= 4'h0;
    end else begin
      // history starts from the reset value
      latch_prev_q    <= ctrl1_q[`GTC_BIT_LATCH];
      counter_latch_o <= {`GTC_PORTS{ctrl1_q[`GTC_BIT_LATCH] & ~latch_prev_q}} & framer_latch_en_i;
    end
  end

  // ----------------------------------------------------------------------
  // status pin routing
  // ----------------------------------------------------------------------
  // reserved codes fall back to code zero
  assign sel_w    = (ctrl1_q[`GTC_SEL_HI:`GTC_SEL_LO] > `GTC_SEL_MAX) ? 3'h0
                                                                      : ctrl1_q[`GTC_SEL_HI:`GTC_SEL_LO];
  assign compat_w = ctrl1_q[`GTC_BIT_COMPAT];

  // registered so the pins never see a glitch from the select change
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_grp_a_o <= 4'h0;
      status_grp_b_o <= 4'h0;
    end else begin
      // low select bit picks frame loss or clock loss
      status_grp_a_o <= sel_w[0] ? tx_clock_loss_i : rx_loss_of_frame_i;
      // upper select bits pick alarm, freeze or signal loss
      case (sel_w[2:1])
        2'h0:    status_grp_b_o <= alarm_output_i;
        2'h1:    status_grp_b_o <= rx_signaling_freeze_i;
        2'h2:    status_grp_b_o <= framer_loss_of_signal_i;
        default: status_grp_b_o <= alarm_output_i;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin-compatibility mux
  // ----------------------------------------------------------------------
  // pins take the status groups one cycle after the groups update
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_system_clock_o    <= 3'h0;
      rx_system_clock_oe_o <= 3'h0;
      tx_system_clock_o    <= 3'h0;
      tx_system_clock_oe_o <= 3'h0;
      clock_output_pin_o   <= 1'b0;
      serial_select_o      <= 1'b0;
      serial_select_oe_o   <= 1'b0;
      tx_sync_plain_o      <= 1'b0;
    end else if (compat_w) begin
      // clock pins carry the status groups
      rx_system_clock_o    <= status_grp_a_o[3:1];
      rx_system_clock_oe_o <= 3'h7;
      tx_system_clock_o    <= status_grp_b_o[3:1];
      tx_system_clock_oe_o <= 3'h7;
      clock_output_pin_o   <= status_grp_a_o[0];
      serial_select_o      <= status_grp_b_o[0];
      serial_select_oe_o   <= 1'b1;
      tx_sync_plain_o      <= 1'b1;
    end else begin
      // clock pins stay inputs, normal clock out
      rx_system_clock_o    <= 3'h0;
      rx_system_clock_oe_o <= 3'h0;
      tx_system_clock_o    <= 3'h0;
      tx_system_clock_oe_o <= 3'h0;
      clock_output_pin_o   <= clock_output_src_i;
      serial_select_o      <= 1'b0;
      serial_select_oe_o   <= 1'b0;
      tx_sync_plain_o      <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interleaved bus mode and plain register outputs
  // ----------------------------------------------------------------------
  // the default, internal mux, is the recommended setting
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_mux_en_o                <= 1'b1;
      wired_or_en_o               <= 1'b0;
      framer_control_one_o        <= `GTC_RST_REG;
      transceiver_control_three_o <= `GTC_RST_REG;
      clock_control_one_o         <= `GTC_RST_REG;
      clock_control_three_o       <= `GTC_RST_REG;
      software_reset_o            <= `GTC_RST_REG;
    end else begin
      // ganged mode shuts the internal mux
      int_mux_en_o                <= ~ctrl1_q[`GTC_BIT_GANGED];
      wired_or_en_o               <= ctrl1_q[`GTC_BIT_GANGED];
      framer_control_one_o        <= frm_ctrl1_q;
      transceiver_control_three_o <= ctrl3_q;
      clock_control_one_o         <= clk_ctrl1_q;
      clock_control_three_o       <= clk_ctrl3_q;
      software_reset_o            <= sw_reset_q;
    end
  end

endmodule

`default_nettype wire

// *** testbench/gtc_host_model.sv ***
/*
  Host processor model: Avalon-MM master issuing single transfers.
  Assumes: one clock; the slave answers by dropping waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module gtc_host_model (
  // clock and slave answer
  input  wire logic        sys_clk_i,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [31:0] avs_readdata_o,
  // request lines
  output var  logic [7:0]  avs_address_i,
  output var  logic        avs_read_i, avs_write_i,
  output var  logic [31:0] avs_writedata_i,
  output var  logic [3:0]  avs_byteenable_i
);
  // idle bus at time zero; lane zero always enabled
  initial {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i} = {42'h0, 4'hF};
  // one transfer; released lines show the inverse so stale values never match
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, 24'h0, d, we, !we};
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {~a, ~{24'h0, d}, 2'h0};
  endtask
endmodule
`default_nettype wire

// *** testbench/gtc_regbank_chk_asserts.sv ***
/*
  Port checker of the global control register bank.
  Assumes: bound to gtc_regbank; one clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.vh"
module gtc_regbank_chk (
  // clock, reset and bus
  input wire logic        sys_clk_i, rst_i, avs_write_i, avs_waitrequest_o, avs_read_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  // status sources and latch acceptance
  input wire logic [3:0]  rx_loss_of_frame_i, tx_clock_loss_i, alarm_output_i,
  input wire logic [3:0]  rx_signaling_freeze_i, framer_loss_of_signal_i, framer_latch_en_i,
  // watched outputs
  input wire logic [3:0]  status_grp_a_o, status_grp_b_o, counter_latch_o,
  input wire logic [2:0]  rx_system_clock_o, rx_system_clock_oe_o,
  input wire logic        int_mux_en_o, wired_or_en_o, irq_o, interrupt_pin_n_o
);
  // ----------------------------------------------------------------------
  // shadow of control one
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic       rst_d_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // rst_d_q masks the first edge, where $past still sees reset-era inputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q  <= `GTC_RST_REG;
      rst_d_q <= 1'h1;
    end else begin
      rst_d_q <= 1'h0;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `GTC_IDX_CTRL1 && avs_byteenable_i[0])
        ctrl_q <= avs_writedata_i[7:0] & `GTC_CTRL1_WMASK;
    end
  end
  // expected groups; codes six and seven fall back to code zero
  function automatic logic [3:0] grp_a(logic [2:0] s, logic [3:0] rl, logic [3:0] lt);
    return (s < 3'h6 && s[0]) ? lt : rl;
  endfunction
  function automatic logic [3:0] grp_b(logic [2:0] s, logic [3:0] al, logic [3:0] fz, logic [3:0] fl);
    return (s == 3'h2 || s == 3'h3) ? fz : (s == 3'h4 || s == 3'h5) ? fl : al;
  endfunction
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  grp_a_sel_a: assert property (!rst_d_q |-> status_grp_a_o ==
    grp_a($past(ctrl_q[7:5]), $past(rx_loss_of_frame_i), $past(tx_clock_loss_i))) else $error("group a wrong");
  grp_b_sel_a: assert property (!rst_d_q |-> status_grp_b_o == grp_b($past(ctrl_q[7:5]),
    $past(alarm_output_i), $past(rx_signaling_freeze_i), $past(framer_loss_of_signal_i))) else $error("group b wrong");
  compat_pins_a: assert property (!rst_d_q |-> rx_system_clock_oe_o == {3{$past(ctrl_q[3])}} &&
    rx_system_clock_o == ($past(ctrl_q[3]) ? $past(status_grp_a_o[3:1]) : 3'h0)) else $error("rx clock pins wrong");
  mux_select_a: assert property (!rst_d_q |-> wired_or_en_o == $past(ctrl_q[2]) &&
    int_mux_en_o == !$past(ctrl_q[2])) else $error("bus mux select wrong");
  latch_edge_a: assert property (!rst_d_q |-> counter_latch_o ==
    (($past(ctrl_q[1]) && !$past(ctrl_q[1], 2)) ? $past(framer_latch_en_i) : 4'h0)) else $error("latch pulse wrong");
  pin_inhibit_a: assert property (!rst_d_q && $past(ctrl_q[0]) |-> interrupt_pin_n_o)
    else $error("interrupt pin not held high");
  pin_follow_a: assert property (!rst_d_q && !$past(ctrl_q[0]) |-> interrupt_pin_n_o == !irq_o)
    else $error("interrupt pin does not follow request");
endmodule
bind gtc_regbank gtc_regbank_chk i_gtc_regbank_chk (.*);
`default_nettype wire

// *** testbench/gtc_regbank_tb.sv ***
/*
  Self-checking bench of the global control register bank.
  Assumes: host model drives the bus; the bench drives every other input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.vh"
module gtc_regbank_tb;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, clock_output_src_i;
  logic [7:0]  avs_address_i, framer_control_one_o, transceiver_control_three_o, clock_control_one_o;
  logic [7:0]  clock_control_three_o, software_reset_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i, framer_event_i, bert_event_i, liu_event_i, framer_latch_en_i;
  logic [3:0]  rx_loss_of_frame_i, tx_clock_loss_i, alarm_output_i, rx_signaling_freeze_i;
  logic [3:0]  framer_loss_of_signal_i, status_grp_a_o, status_grp_b_o, counter_latch_o;
  logic [2:0]  rx_system_clock_o, rx_system_clock_oe_o, tx_system_clock_o, tx_system_clock_oe_o;
  logic        clock_output_pin_o, serial_select_o, serial_select_oe_o, tx_sync_plain_o;
  logic        int_mux_en_o, wired_or_en_o, irq_o, interrupt_pin_n_o;
  int          fails, cmp_count;
  gtc_regbank i_gtc_regbank (.*);
  gtc_host_model host (.*);
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %0h seen %0h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    host.bus(1'h1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    host.bus(1'h0, a, 8'h00, q);
    chk($sformatf("reg %0h", a), {24'h0, e}, q);
  endtask
  // pin mux lags a write by two edges
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic watch(logic [3:0] e, int n);
    logic [3:0] acc = 4'h0;
    int         c = 0;
    repeat (4) begin
      @(negedge sys_clk_i);
      acc |= counter_latch_o;
      c += (counter_latch_o != 4'h0);
    end
    chk("latch set", e, acc);
    chk("latch pulses", n, c);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    // look away from the edge that launches the outputs
    @(negedge sys_clk_i);
    chk("reset pins", 2'h3, {int_mux_en_o, interrupt_pin_n_o});
    for (int i = 8'hF0; i <= 8'hFE; i++) rd(8'(i), (i == `GTC_IDX_DEV_ID) ? `GTC_ID_VALUE : 8'h00);
  endtask
  task automatic t_regs;
    logic [7:0] rw [8] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hFC, 8'hFD, 8'hFE};
    foreach (rw[i]) begin
      wr(rw[i], 8'hC3);
      rd(rw[i], (rw[i] >= 8'hFC) ? 8'h03 : 8'hC3);
    end
    chk("copies", 24'hC3C3C3, {framer_control_one_o, transceiver_control_three_o, clock_control_one_o});
    chk("copies", 16'hC3C3, {clock_control_three_o, software_reset_o});
    wr(8'hF0, 8'h10);
    rd(8'hF0, 8'h00);
    wr(8'hF5, 8'h00);
    wr(8'hF7, 8'h00);
    wr(8'hF8, 8'hFF);
    rd(8'hF8, `GTC_ID_VALUE);
    rd(8'hF7, 8'h00);
    rd(8'h10, 8'h00);
  endtask
  // every selection code, reserved ones included
  task automatic t_sel;
    @(posedge sys_clk_i);
    {rx_loss_of_frame_i, tx_clock_loss_i, alarm_output_i} <= 12'h695;
    {rx_signaling_freeze_i, framer_loss_of_signal_i} <= 8'hAC;
    for (int s = 0; s < 8; s++) begin
      wr(8'hF0, 8'(s << 5));
      settle;
      chk("group a", (s < 6 && s % 2) ? 4'h9 : 4'h6, status_grp_a_o);
      chk("group b", (s inside {2, 3}) ? 4'hA : (s inside {4, 5}) ? 4'hC : 4'h5, status_grp_b_o);
    end
  endtask
  task automatic t_compat;
    wr(8'hF0, 8'h08);
    settle;
    chk("rx clock pins", 6'h3B, {rx_system_clock_oe_o, rx_system_clock_o});
    chk("tx clock pins", 6'h3A, {tx_system_clock_oe_o, tx_system_clock_o});
    chk("misc pins", 4'h7, {clock_output_pin_o, serial_select_o, serial_select_oe_o, tx_sync_plain_o});
    @(posedge sys_clk_i);
    clock_output_src_i <= 1'h1;
    wr(8'hF0, 8'h00);
    settle;
    chk("clock pins", 12'h000, {rx_system_clock_oe_o, rx_system_clock_o, tx_system_clock_oe_o, tx_system_clock_o});
    chk("misc pins", 4'h8, {clock_output_pin_o, serial_select_o, serial_select_oe_o, tx_sync_plain_o});
  endtask
  task automatic t_gang;
    wr(8'hF0, 8'h04);
    wr(8'hF1, 8'h40);
    settle;
    chk("ganged mux", 2'h1, {int_mux_en_o, wired_or_en_o});
    wr(8'hF0, 8'h00);
    settle;
    chk("internal mux", 2'h2, {int_mux_en_o, wired_or_en_o});
  endtask
  // held one must not relatch; zero then one must
  task automatic t_latch;
    @(posedge sys_clk_i);
    framer_latch_en_i <= 4'h5;
    wr(8'hF0, 8'h02);
    watch(4'h5, 1);
    wr(8'hF0, 8'h02);
    watch(4'h0, 0);
    // watch ends on a falling edge; inputs only move on the rising one
    @(posedge sys_clk_i);
    framer_latch_en_i <= 4'hA;
    wr(8'hF0, 8'h00);
    wr(8'hF0, 8'h02);
    watch(4'hA, 1);
    wr(8'hF0, 8'h00);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 3; i++) wr(8'(8'hFC + i), 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      {liu_event_i, bert_event_i, framer_event_i} <= 12'h001 << (5 * i);
      @(posedge sys_clk_i);
      {liu_event_i, bert_event_i, framer_event_i} <= 12'h000;
      settle;
      rd(8'(8'hF9 + i), 8'(1 << i));
      chk("masked", 2'h1, {irq_o, interrupt_pin_n_o});
      wr(8'(8'hFC + i), 8'(1 << i));
      settle;
      chk("unmasked", 2'h2, {irq_o, interrupt_pin_n_o});
      wr(8'hF0, 8'h01);
      settle;
      chk("inhibited", 2'h3, {irq_o, interrupt_pin_n_o});
      wr(8'hF0, 8'h00);
      wr(8'(8'hF9 + i), 8'(1 << i));
      settle;
      chk("cleared", 2'h1, {irq_o, interrupt_pin_n_o});
    end
  endtask
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {sys_clk_i, rst_i, fails, cmp_count, clock_output_src_i} = {2'h1, 64'h0, 1'h0};
    {framer_event_i, bert_event_i, liu_event_i, framer_latch_en_i} = 16'h0;
    {rx_loss_of_frame_i, tx_clock_loss_i, alarm_output_i, rx_signaling_freeze_i, framer_loss_of_signal_i} = 20'h0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    t_reset();
    t_regs();
    t_sel();
    t_compat();
    t_gang();
    t_latch();
    t_irq();
    tally_and_finish();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
